// ---- logic/ppe_pkg.sv ----
package ppe_pkg;

	// register offsets
	localparam logic [7:0] OFS_POWER_PATH_CONTROL    = 8'h01;
	localparam logic [7:0] OFS_EVENT_FLAGS_AND_MASKS = 8'h02;

	// reset values
	localparam logic [7:0] RST_POWER_PATH_CONTROL    = 8'h3d;
	localparam logic [7:0] RST_EVENT_FLAGS_AND_MASKS = 8'h80;
	localparam logic [7:0] UNMAPPED_READ_VALUE       = 8'h00;

	// power path control field positions
	localparam int unsigned BIT_AC_DETECT_SINK_CTRL  = 7;
	localparam int unsigned BIT_USB_DETECT_SINK_CTRL = 6;
	localparam int unsigned BIT_AC_PATH_ON           = 5;
	localparam int unsigned BIT_USB_PATH_ON          = 4;
	localparam int unsigned BIT_AC_LIMIT_HI          = 3;
	localparam int unsigned BIT_AC_LIMIT_LO          = 2;
	localparam int unsigned BIT_USB_LIMIT_HI         = 1;
	localparam int unsigned BIT_USB_LIMIT_LO         = 0;

	// event register field positions
	localparam int unsigned BIT_EVT_RESERVED_RW      = 7;
	localparam int unsigned BIT_BUTTON_CHANGE_MASK   = 6;
	localparam int unsigned BIT_AC_CHANGE_MASK       = 5;
	localparam int unsigned BIT_USB_CHANGE_MASK      = 4;
	localparam int unsigned BIT_EVT_RESERVED_RO      = 3;
	localparam int unsigned BIT_BUTTON_CHANGE_FLAG   = 2;
	localparam int unsigned BIT_AC_CHANGE_FLAG       = 1;
	localparam int unsigned BIT_USB_CHANGE_FLAG      = 0;

	// current limit table in ma
	localparam logic [11:0] ILIM_MA_CODE0     = 12'd100;
	localparam logic [11:0] ILIM_MA_CODE1     = 12'd500;
	localparam logic [11:0] ILIM_MA_CODE2     = 12'd1300;
	localparam logic [11:0] ILIM_MA_AC_CODE3  = 12'd2500;
	localparam logic [11:0] ILIM_MA_USB_CODE3 = 12'd1800;

	// event source order inside a vector
	localparam int unsigned EVT_USB    = 0;
	localparam int unsigned EVT_AC     = 1;
	localparam int unsigned EVT_BUTTON = 2;
	localparam int unsigned EVT_COUNT  = 3;

	// register access request from the serial interface
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ppe_reg_req_t;

	// register access answer
	typedef struct packed {
		logic       ack;
		logic [7:0] rdata;
	} ppe_reg_resp_t;

	// present input levels for the separate status register
	typedef struct packed {
		logic button;
		logic ac;
		logic usb;
	} ppe_status_t;

	// analog power path controls
	typedef struct packed {
		logic        ac_path_on;
		logic        usb_path_on;
		logic        usb_suspend;
		logic        ac_sink_on;
		logic        usb_sink_on;
		logic [1:0]  ac_limit_code;
		logic [1:0]  usb_limit_code;
		logic [11:0] ac_limit_ma;
		logic [11:0] usb_limit_ma;
	} ppe_path_ctrl_t;

endpackage

// ---- logic/ppe_change_det.sv ----
`timescale 1ns/10ps
module ppe_change_det
#(
	parameter int unsigned WIDTH = 3
)
(
	// clock and reset
	input  wire logic             i_mclk,
	input  wire logic             i_rstn,
	// sampled levels
	input  wire logic [WIDTH-1:0] i_level,
	// one cycle change pulses and last level
	output logic      [WIDTH-1:0] o_change,
	output logic      [WIDTH-1:0] o_level
);

	logic [WIDTH-1:0] prev_reg;
	logic             primed_reg;

	// first sample after reset only loads history
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
			primed_reg <= 1'b0;
		else
			primed_reg <= 1'b1;
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
			prev_reg <= '0;
		else
			prev_reg <= i_level;
	end

	// either direction counts
	assign o_change = primed_reg ? (prev_reg ^ i_level) : '0;
	assign o_level  = prev_reg;

endmodule // ppe_change_det

// ---- logic/ppe_regs.sv ----
`timescale 1ns/10ps
module ppe_regs
(
	// clock and reset
	input  wire logic                    i_mclk,
	input  wire logic                    i_rstn,
	// register access
	input  wire ppe_pkg::ppe_reg_req_t   i_req,
	output ppe_pkg::ppe_reg_resp_t       o_resp,
	// supply and button levels
	input  wire logic                    i_push_button_input,
	input  wire logic                    i_ac_power_valid,
	input  wire logic                    i_usb_power_valid,
	input  wire logic                    i_ac_below_detect,
	input  wire logic                    i_usb_below_detect,
	// power path controls
	output ppe_pkg::ppe_path_ctrl_t      o_path,
	// present levels
	output ppe_pkg::ppe_status_t         o_status,
	// interrupt, active low
	output logic                         o_int_n
);

	// power path control fields
	logic        ac_detect_sink_ctrl_reg;
	logic        usb_detect_sink_ctrl_reg;
	logic        ac_path_on_reg;
	logic        usb_path_on_reg;
	logic        ac_limit_hi_reg;
	logic        usb_limit_hi_reg;
	// event register fields
	logic        evt_reserved_reg;
	logic        button_change_mask_reg;
	logic        ac_change_mask_reg;
	logic        usb_change_mask_reg;
	logic [2:0]  flags_reg;
	logic [2:0]  flags_next;
	// access decode
	logic        sel_path;
	logic        sel_evt;
	logic        wr_path;
	logic        wr_evt;
	logic        rd_evt;
	logic        take;
	logic [7:0]  path_value;
	logic [7:0]  evt_value;
	logic [7:0]  rdata_next;
	// events
	logic [2:0]  levels;
	logic [2:0]  changes;
	logic [2:0]  last_levels;
	logic [2:0]  masks;
	logic        int_n_next;
	logic        int_n_reg;
	logic        ack_reg;
	logic [7:0]  rdata_reg;
	ppe_pkg::ppe_path_ctrl_t path_reg;
	ppe_pkg::ppe_path_ctrl_t path_next;

	// current limit code to milliamps
	function automatic logic [11:0] limit_ma(input logic [1:0] code, input logic [11:0] top);
		logic [11:0] ma;
		ma = ppe_pkg::ILIM_MA_CODE0;
		unique case (code)
			2'b00: ma = ppe_pkg::ILIM_MA_CODE0;
			2'b01: ma = ppe_pkg::ILIM_MA_CODE1;
			2'b10: ma = ppe_pkg::ILIM_MA_CODE2;
			2'b11: ma = top;
		endcase
		return ma;
	endfunction

	// address decode
	assign sel_path = (i_req.addr == ppe_pkg::OFS_POWER_PATH_CONTROL);
	assign sel_evt  = (i_req.addr == ppe_pkg::OFS_EVENT_FLAGS_AND_MASKS);
	// a request held through its answer is taken once
	assign take     = !ack_reg;
	assign wr_path  = i_req.wr && sel_path && take;
	assign wr_evt   = i_req.wr && sel_evt && take;
	assign rd_evt   = i_req.rd && sel_evt && take;

	// power path control register
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			ac_detect_sink_ctrl_reg  <= ppe_pkg::RST_POWER_PATH_CONTROL[ppe_pkg::BIT_AC_DETECT_SINK_CTRL];
			usb_detect_sink_ctrl_reg <= ppe_pkg::RST_POWER_PATH_CONTROL[ppe_pkg::BIT_USB_DETECT_SINK_CTRL];
			ac_path_on_reg           <= ppe_pkg::RST_POWER_PATH_CONTROL[ppe_pkg::BIT_AC_PATH_ON];
			usb_path_on_reg          <= ppe_pkg::RST_POWER_PATH_CONTROL[ppe_pkg::BIT_USB_PATH_ON];
			ac_limit_hi_reg          <= ppe_pkg::RST_POWER_PATH_CONTROL[ppe_pkg::BIT_AC_LIMIT_HI];
			usb_limit_hi_reg         <= ppe_pkg::RST_POWER_PATH_CONTROL[ppe_pkg::BIT_USB_LIMIT_HI];
		end
		else if (wr_path)
		begin
			// both sink bits land in the same write
			ac_detect_sink_ctrl_reg  <= i_req.wdata[ppe_pkg::BIT_AC_DETECT_SINK_CTRL];
			usb_detect_sink_ctrl_reg <= i_req.wdata[ppe_pkg::BIT_USB_DETECT_SINK_CTRL];
			ac_path_on_reg           <= i_req.wdata[ppe_pkg::BIT_AC_PATH_ON];
			usb_path_on_reg          <= i_req.wdata[ppe_pkg::BIT_USB_PATH_ON];
			// low limit bits are not stored
			ac_limit_hi_reg          <= i_req.wdata[ppe_pkg::BIT_AC_LIMIT_HI];
			usb_limit_hi_reg         <= i_req.wdata[ppe_pkg::BIT_USB_LIMIT_HI];
		end
	end

	// read image of power path control
	always_comb
	begin
		path_value = 8'h00;
		path_value[ppe_pkg::BIT_AC_DETECT_SINK_CTRL]  = ac_detect_sink_ctrl_reg;
		path_value[ppe_pkg::BIT_USB_DETECT_SINK_CTRL] = usb_detect_sink_ctrl_reg;
		path_value[ppe_pkg::BIT_AC_PATH_ON]           = ac_path_on_reg;
		path_value[ppe_pkg::BIT_USB_PATH_ON]          = usb_path_on_reg;
		path_value[ppe_pkg::BIT_AC_LIMIT_HI]          = ac_limit_hi_reg;
		path_value[ppe_pkg::BIT_AC_LIMIT_LO]          =
			ppe_pkg::RST_POWER_PATH_CONTROL[ppe_pkg::BIT_AC_LIMIT_LO];
		path_value[ppe_pkg::BIT_USB_LIMIT_HI]         = usb_limit_hi_reg;
		path_value[ppe_pkg::BIT_USB_LIMIT_LO]         =
			ppe_pkg::RST_POWER_PATH_CONTROL[ppe_pkg::BIT_USB_LIMIT_LO];
	end

	// power path steering
	always_comb
	begin
		path_next = '0;
		path_next.ac_path_on  = ac_path_on_reg;
		path_next.usb_path_on = usb_path_on_reg;
		path_next.usb_suspend = !usb_path_on_reg;
		// sinks are off whenever their control bit is set
		path_next.ac_sink_on  = !ac_detect_sink_ctrl_reg && i_usb_power_valid
			&& i_ac_below_detect;
		path_next.usb_sink_on = !usb_detect_sink_ctrl_reg && i_ac_power_valid
			&& i_usb_below_detect;
		path_next.ac_limit_code  = path_value[ppe_pkg::BIT_AC_LIMIT_HI:ppe_pkg::BIT_AC_LIMIT_LO];
		path_next.usb_limit_code = path_value[ppe_pkg::BIT_USB_LIMIT_HI:ppe_pkg::BIT_USB_LIMIT_LO];
		path_next.ac_limit_ma    = limit_ma(path_next.ac_limit_code,
			ppe_pkg::ILIM_MA_AC_CODE3);
		path_next.usb_limit_ma   = limit_ma(path_next.usb_limit_code,
			ppe_pkg::ILIM_MA_USB_CODE3);
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
			path_reg <= '0;
		else
			path_reg <= path_next;
	end

	assign o_path = path_reg;

	// change detection on button, ac and usb
	assign levels[ppe_pkg::EVT_USB]    = i_usb_power_valid;
	assign levels[ppe_pkg::EVT_AC]     = i_ac_power_valid;
	assign levels[ppe_pkg::EVT_BUTTON] = i_push_button_input;

	ppe_change_det
	#(
		.WIDTH (ppe_pkg::EVT_COUNT)
	)
	u_change_det
	(
		.i_mclk   (i_mclk),
		.i_rstn   (i_rstn),
		.i_level  (levels),
		.o_change (changes),
		.o_level  (last_levels)
	);

	// present levels for the status register
	assign o_status.button = last_levels[ppe_pkg::EVT_BUTTON];
	assign o_status.ac     = last_levels[ppe_pkg::EVT_AC];
	assign o_status.usb    = last_levels[ppe_pkg::EVT_USB];

	// event register writable fields
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			evt_reserved_reg       <= ppe_pkg::RST_EVENT_FLAGS_AND_MASKS[ppe_pkg::BIT_EVT_RESERVED_RW];
			button_change_mask_reg <= ppe_pkg::RST_EVENT_FLAGS_AND_MASKS[ppe_pkg::BIT_BUTTON_CHANGE_MASK];
			ac_change_mask_reg     <= ppe_pkg::RST_EVENT_FLAGS_AND_MASKS[ppe_pkg::BIT_AC_CHANGE_MASK];
			usb_change_mask_reg    <= ppe_pkg::RST_EVENT_FLAGS_AND_MASKS[ppe_pkg::BIT_USB_CHANGE_MASK];
		end
		else if (wr_evt)
		begin
			evt_reserved_reg       <= i_req.wdata[ppe_pkg::BIT_EVT_RESERVED_RW];
			button_change_mask_reg <= i_req.wdata[ppe_pkg::BIT_BUTTON_CHANGE_MASK];
			ac_change_mask_reg     <= i_req.wdata[ppe_pkg::BIT_AC_CHANGE_MASK];
			usb_change_mask_reg    <= i_req.wdata[ppe_pkg::BIT_USB_CHANGE_MASK];
		end
	end

	// flags: a change in the clearing cycle still sets
	always_comb
	begin
		flags_next = flags_reg;
		if (rd_evt)
			flags_next = 3'b000;
		flags_next[ppe_pkg::EVT_BUTTON] = flags_next[ppe_pkg::EVT_BUTTON]
			| changes[ppe_pkg::EVT_BUTTON];
		flags_next[ppe_pkg::EVT_AC]     = flags_next[ppe_pkg::EVT_AC]
			| changes[ppe_pkg::EVT_AC];
		flags_next[ppe_pkg::EVT_USB]    = flags_next[ppe_pkg::EVT_USB]
			| changes[ppe_pkg::EVT_USB];
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
			flags_reg <= 3'b000;
		else
			flags_reg <= flags_next;
	end

	// read image of event register
	always_comb
	begin
		evt_value = 8'h00;
		evt_value[ppe_pkg::BIT_EVT_RESERVED_RW]    = evt_reserved_reg;
		evt_value[ppe_pkg::BIT_BUTTON_CHANGE_MASK] = button_change_mask_reg;
		evt_value[ppe_pkg::BIT_AC_CHANGE_MASK]     = ac_change_mask_reg;
		evt_value[ppe_pkg::BIT_USB_CHANGE_MASK]    = usb_change_mask_reg;
		evt_value[ppe_pkg::BIT_EVT_RESERVED_RO]    = 1'b0;
		evt_value[ppe_pkg::BIT_BUTTON_CHANGE_FLAG] = flags_reg[ppe_pkg::EVT_BUTTON];
		evt_value[ppe_pkg::BIT_AC_CHANGE_FLAG]     = flags_reg[ppe_pkg::EVT_AC];
		evt_value[ppe_pkg::BIT_USB_CHANGE_FLAG]    = flags_reg[ppe_pkg::EVT_USB];
	end

	// interrupt from unmasked flags
	assign masks[ppe_pkg::EVT_BUTTON] = button_change_mask_reg;
	assign masks[ppe_pkg::EVT_AC]     = ac_change_mask_reg;
	assign masks[ppe_pkg::EVT_USB]    = usb_change_mask_reg;
	assign int_n_next = !(|(flags_next & ~masks));

	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
			int_n_reg <= 1'b1;
		else
			int_n_reg <= int_n_next;
	end

	assign o_int_n = int_n_reg;

	// read data returns the value before any clear
	always_comb
	begin
		rdata_next = ppe_pkg::UNMAPPED_READ_VALUE;
		if (sel_path)
			rdata_next = path_value;
		else if (sel_evt)
			rdata_next = evt_value;
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
			rdata_reg <= 8'h00;
		else if (i_req.rd && take)
			rdata_reg <= rdata_next;
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
			ack_reg <= 1'b0;
		else
			ack_reg <= (i_req.rd || i_req.wr) && take;
	end

	assign o_resp.ack   = ack_reg;
	assign o_resp.rdata = rdata_reg;

endmodule // ppe_regs

// ---- test/ppe_regs_asserts.sv ----
`timescale 1ns/10ps
module ppe_regs_asserts
(
	// clock and reset
	input wire logic                    i_mclk,
	input wire logic                    i_rstn,
	// register access
	input wire ppe_pkg::ppe_reg_req_t   i_req,
	input wire ppe_pkg::ppe_reg_resp_t  o_resp,
	// levels
	input wire logic                    i_push_button_input,
	input wire logic                    i_ac_power_valid,
	input wire logic                    i_usb_power_valid,
	input wire logic                    i_ac_below_detect,
	input wire logic                    i_usb_below_detect,
	// outputs
	input wire ppe_pkg::ppe_path_ctrl_t o_path,
	input wire ppe_pkg::ppe_status_t    o_status,
	input wire logic                    o_int_n
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);
	logic [2:0] lvl;
	logic       wr_path_take;
	logic       rd_evt_take;
	assign lvl = {i_push_button_input, i_ac_power_valid, i_usb_power_valid};
	// accesses the register port actually takes, not the held cycle under ack
	assign wr_path_take = i_req.wr && i_req.addr == 8'h01 && !o_resp.ack;
	assign rd_evt_take  = i_req.rd && i_req.addr == 8'h02 && !o_resp.ack;
	function automatic logic [11:0] lim_ma(input logic [1:0] c, input logic ac);
		case (c)
			2'b00: lim_ma = 12'h064;
			2'b01: lim_ma = 12'h1f4;
			2'b10: lim_ma = 12'h514;
			default: lim_ma = ac ? 12'h9c4 : 12'h708;
		endcase
	endfunction
	// single write of the power path register
	sequence s_power_path_control_wr;
		wr_path_take ##1 !wr_path_take;
	endsequence
	sequence s_sink_off_wr;
		i_req.wdata[7:6] == 2'b11 ##0 s_power_path_control_wr;
	endsequence
	a_sinks_forced_off: assert property (s_sink_off_wr |=>
		!o_path.ac_sink_on && !o_path.usb_sink_on) else $error("sinks not off");
	a_path_enable_set: assert property (s_power_path_control_wr |=>
		o_path.ac_path_on == $past(i_req.wdata[5], 2)
		&& o_path.usb_path_on == $past(i_req.wdata[4], 2)) else $error("path enable wrong");
	a_ac_limit_ma: assert property ($past(i_rstn) |->
		o_path.ac_limit_ma == lim_ma(o_path.ac_limit_code, 1'b1)) else $error("ac limit");
	a_usb_limit_ma: assert property ($past(i_rstn) |->
		o_path.usb_limit_ma == lim_ma(o_path.usb_limit_code, 1'b0)) else $error("usb limit");
	a_limit_lsb_fixed: assert property ($past(i_rstn) |->
		o_path.ac_limit_code[0] && o_path.usb_limit_code[0]) else $error("limit lsb moved");
	a_usb_suspend_mirror: assert property ($past(i_rstn) |->
		o_path.usb_suspend != o_path.usb_path_on) else $error("suspend mismatch");
	a_ac_sink_cause: assert property (!(i_usb_power_valid && i_ac_below_detect) |=>
		!o_path.ac_sink_on) else $error("ac sink without cause");
	a_usb_sink_cause: assert property (!(i_ac_power_valid && i_usb_below_detect) |=>
		!o_path.usb_sink_on) else $error("usb sink without cause");
	a_status_delay: assert property ($past(i_rstn) |->
		o_status == $past(lvl)) else $error("status wrong");
	a_event_bit3_zero: assert property (rd_evt_take |=>
		o_resp.rdata[3] == 1'b0) else $error("reserved bit set");
	a_int_needs_change: assert property ($fell(o_int_n) |-> $past(lvl) != $past(lvl, 2)
		|| $past(i_req.wr) || $past(i_req.wr, 2)) else $error("int without change");
	a_int_read_clear: assert property (rd_evt_take && lvl == $past(lvl)
		|=> o_int_n) else $error("int not cleared by read");
endmodule // ppe_regs_asserts

bind ppe_regs ppe_regs_asserts u_chk
(
	.i_mclk(i_mclk), .i_rstn(i_rstn), .i_req(i_req), .o_resp(o_resp),
	.i_push_button_input(i_push_button_input), .i_ac_power_valid(i_ac_power_valid),
	.i_usb_power_valid(i_usb_power_valid), .i_ac_below_detect(i_ac_below_detect),
	.i_usb_below_detect(i_usb_below_detect), .o_path(o_path), .o_status(o_status),
	.o_int_n(o_int_n)
);

// ---- test/ppe_host_model.sv ----
`timescale 1ns/10ps
module ppe_host_model
(
	// clock
	input  wire logic                   i_mclk,
	// register port
	input  wire ppe_pkg::ppe_reg_resp_t i_resp,
	output ppe_pkg::ppe_reg_req_t       o_req
);
	initial o_req = '0;
	// one byte access, bounded wait for the answer
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] wd,
		output logic [7:0] rdat, output logic ok);
		int k;
		ok = 1'b0;
		rdat = 8'h00;
		@(negedge i_mclk);
		o_req = {~w, w, a, wd};
		for (k = 0; k < 4 && !ok; k++)
		begin
			@(negedge i_mclk);
			ok = (i_resp.ack === 1'b1);
		end
		// hold through the rising edge that samples ack, then take data and release
		@(negedge i_mclk);
		rdat = i_resp.rdata;
		o_req = {2'b00, ~a, ~wd};
	endtask
endmodule // ppe_host_model

// ---- test/ppe_regs_test.sv ----
`timescale 1ns/10ps
module ppe_regs_test;
	logic                    i_mclk;
	logic                    i_rstn;
	logic [2:0]              lvl;
	logic                    acb;
	logic                    usbb;
	ppe_pkg::ppe_reg_req_t   req;
	ppe_pkg::ppe_reg_resp_t  resp;
	ppe_pkg::ppe_path_ctrl_t path;
	ppe_pkg::ppe_status_t    status;
	logic                    int_n;
	logic [7:0]              rd;
	logic [7:0]              d;
	logic [7:0]              m;
	logic                    ok;
	int                      miscompares;
	int                      checked;
	int                      i;
	int                      s;

	ppe_host_model u_host (.i_mclk(i_mclk), .i_resp(resp), .o_req(req));
	ppe_regs i_dut
	(
		.i_mclk(i_mclk), .i_rstn(i_rstn), .i_req(req), .o_resp(resp),
		.i_push_button_input(lvl[2]), .i_ac_power_valid(lvl[1]),
		.i_usb_power_valid(lvl[0]), .i_ac_below_detect(acb),
		.i_usb_below_detect(usbb), .o_path(path), .o_status(status), .o_int_n(int_n)
	);

	initial
	begin
		i_mclk = 1'b0;
		forever #2.5 i_mclk = ~i_mclk;
	end

	function automatic logic [11:0] lim(input logic [1:0] c, input logic ac);
		case (c)
			2'b00: lim = 12'h064;
			2'b01: lim = 12'h1f4;
			2'b10: lim = 12'h514;
			default: lim = ac ? 12'h9c4 : 12'h708;
		endcase
	endfunction

	task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("miscompares %0d checked %0d", miscompares, checked);
		if (miscompares == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] wd);
		u_host.access(w, a, wd, rd, ok);
		if (!ok)
		begin
			miscompares++;
			finish_test();
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		check("register read", {8'h00, rd}, {8'h00, exp});
	endtask

	initial
	begin
		i_rstn = 1'b0;
		lvl = 3'b000;
		acb = 1'b0;
		usbb = 1'b0;
		miscompares = 0;
		checked = 0;
		void'($urandom(32'hece968f2));
		repeat (2) @(negedge i_mclk);
		i_rstn = 1'b1;
		rd_chk(8'h01, 8'h3d);
		rd_chk(8'h02, 8'h80);
		// read-only bits and unmapped offsets ignore writes
		bus(1'b1, 8'h02, 8'h8f);
		rd_chk(8'h02, 8'h80);
		bus(1'b1, 8'h03, 8'hff);
		rd_chk(8'h03, 8'h00);
		rd_chk(8'h01, 8'h3d);
		// enables and limits, sink bits kept equal
		for (i = 0; i < 16; i++)
		begin
			s = $urandom;
			d = {s[0], s[0], i[3], i[2], i[1], s[1], i[0], s[2]};
			bus(1'b1, 8'h01, d);
			repeat (2) @(negedge i_mclk);
			check("path_on", {path.ac_path_on, path.usb_path_on, path.usb_suspend},
				{d[5], d[4], ~d[4]});
			check("ac_limit_ma", path.ac_limit_ma, lim({d[3], 1'b1}, 1'b1));
			check("usb_limit_ma", path.usb_limit_ma, lim({d[1], 1'b1}, 1'b0));
			rd_chk(8'h01, d | 8'h05);
		end
		// detection sinks, automatic then forced off
		for (s = 0; s < 2; s++)
		begin
			bus(1'b1, 8'h01, (s == 1) ? 8'hfd : 8'h3d);
			repeat (8)
			begin
				{lvl, acb, usbb} = 5'($urandom);
				repeat (2) @(negedge i_mclk);
				check("ac_sink_on", path.ac_sink_on, s == 0 && lvl[0] && acb);
				check("usb_sink_on", path.usb_sink_on, s == 0 && lvl[1] && usbb);
				check("status", status, lvl);
			end
		end
		// change flags, masks and interrupt, both edges per source
		for (i = 0; i < 6; i++)
		begin
			m = 8'h80 | (i[0] ? (8'h10 << (i >> 1)) : 8'h00);
			bus(1'b1, 8'h02, m);
			bus(1'b0, 8'h02, 8'h00);
			repeat (2) @(negedge i_mclk);
			lvl[i >> 1] = ~lvl[i >> 1];
			repeat (2) @(negedge i_mclk);
			check("int_n", int_n, i[0]);
			rd_chk(8'h02, m | (8'h01 << (i >> 1)));
			@(negedge i_mclk);
			check("int_n", int_n, 1'b1);
			rd_chk(8'h02, m);
		end
		// reset in mid-run restores both registers
		i_rstn = 1'b0;
		repeat (2) @(negedge i_mclk);
		i_rstn = 1'b1;
		rd_chk(8'h01, 8'h3d);
		rd_chk(8'h02, 8'h80);
		finish_test();
	end
endmodule // ppe_regs_test
